// [bench/bfps_checker.sv]
// Flash bus checker: status word and sequence properties.
// Assumes the link signals and aresetn, all on aclk.
`timescale 1ns/1ps
`default_nettype none
module bfps_checker
    import bfps_pkg::*;
(
    input wire logic                          aclk,
    input wire logic                          aresetn,
    input wire logic                          chip_en,
    input wire logic                          wr_en,
    input wire logic [bfps_pkg::ADDR_W-1:0]   wr_addr,
    input wire logic [bfps_pkg::DATA_W-1:0]   wr_data,
    input wire logic [bfps_pkg::DATA_W-1:0]   rd_data
);
    logic       su;
    logic       fr;
    logic [7:0] cb;
    wire logic       wv = wr_en && chip_en;
    wire logic [7:0] bk = wr_addr[ADDR_W-1:BLK_W];
    wire logic       fl = !rd_data[ST_READY] && !rd_data[ST_BUSY];
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Last write was setup; first write after confirm; target block
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            su <= 1'b0;
            fr <= 1'b0;
        end else if (wv) begin
            su <= (wr_data == CMD_SETUP);
            fr <= su && (wr_data == CMD_CONFIRM) && (bk == cb);
            if (wr_data == CMD_SETUP) cb <= bk;
        end
    end
    a_high_zero: assert property (rd_data[15:8] == ST_HIGH_PAD)
        else $error("status high byte not zero");
    a_confirm_busy: assert property (wv && su && wr_data == CMD_CONFIRM && bk == cb
        && rd_data[7:0] == ST_IDLE_VAL |-> ##[1:3] (!rd_data[ST_READY] && rd_data[ST_BUSY]))
        else $error("confirm did not start setup check");
    a_lock_fail: assert property (rd_data[ST_LOCK] |-> rd_data[ST_FAIL] && rd_data[ST_READY])
        else $error("lock error without fail and ready");
    a_supply_fail: assert property (rd_data[ST_SUPPLY] |-> rd_data[ST_FAIL])
        else $error("supply error without fail");
    a_no_suspend: assert property (!rd_data[ST_SUSP])
        else $error("factory programming suspended");
    a_busy_bound: assert property ($rose(rd_data[ST_BUSY]) |-> ##[1:600] !rd_data[ST_BUSY])
        else $error("buffer busy never cleared");
    a_exit_ready: assert property (wv && fl && bk != cb && wr_data == PAD_WORD
        |-> ##[1:3] rd_data[ST_READY])
        else $error("other block write did not exit");
    a_misalign_fail: assert property (fr && wv && fl && bk == cb
        && wr_addr[BUF_W-1:0] != BUF_ZERO |-> ##[1:3] rd_data[ST_FAIL])
        else $error("misaligned start not failed");
    a_idle_when_busy: assert property (rd_data[ST_BUSY] |-> !wv)
        else $error("flash write while buffer busy");
    c_lock: cover property (rd_data[ST_LOCK]);
    c_supply: cover property (rd_data[ST_SUPPLY]);
    c_exit: cover property (wv && fl && bk != cb && wr_data == PAD_WORD);
endmodule // bfps_checker
`default_nettype wire

// [bench/tb_top.sv]
// Bench: host and sequencer joined over the flash bus, driven by AXI4-Lite.
// Assumes 40 MHz aclk; drives the sequencer's lock and supply pins.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import bfps_pkg::*;
    typedef struct packed {logic wr; logic [3:0] a; logic [31:0] d; logic [1:0] r;} bfps_row_t;
    localparam logic [23:0] WA = 24'h03_0000;
    logic        aclk, aresetn, lockout, locked, a_we;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [3:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, rs;
    logic [23:0] a_addr;
    logic [15:0] a_data;
    int          miscompares = 0, compares = 0, nwe = 0, n;
    bfps_row_t   rows [5] = '{'{1'b0, REG_CTRL, 32'h0000_0008, RESP_OKAY},
        '{1'b0, REG_STAT, 32'h0000_0080, RESP_OKAY}, '{1'b1, REG_STAT, 32'h0000_0000, RESP_SLVERR},
        '{1'b1, 4'h2, 32'h0000_0001, RESP_SLVERR}, '{1'b0, 4'h2, 32'h0000_0000, RESP_SLVERR}};
    bfps_link_if bfps_link_if_i (.aclk(aclk));
    bfps_host bfps_host_i (.aclk(aclk), .aresetn(aresetn), .link(bfps_link_if_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    bfps_device bfps_device_i (.aclk(aclk), .aresetn(aresetn), .link(bfps_link_if_i),
        .supply_lockout_level(lockout), .block_locked(locked), .array_we(a_we),
        .array_addr(a_addr), .array_data(a_data), .standby());
    bfps_checker bfps_checker_i (.aclk(aclk), .aresetn(aresetn),
        .chip_en(bfps_link_if_i.chip_en), .wr_en(bfps_link_if_i.wr_en),
        .wr_addr(bfps_link_if_i.wr_addr), .wr_data(bfps_link_if_i.wr_data),
        .rd_data(bfps_link_if_i.rd_data));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        int k = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            k++;
        end while (bvalid !== 1'b1 && k < 1000);
        r = bresp;
        bready <= 1'b0;
        if (k >= 1000) miscompares++;
    endtask
    task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int k = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            k++;
        end while (rvalid !== 1'b1 && k < 1000);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (k >= 1000) miscompares++;
    endtask
    task automatic poll(input logic [3:0] a, input logic [31:0] m, input logic [31:0] v);
        int k = 0;
        do begin
            axr(a, rd, rs);
            k++;
        end while ((rd & m) !== v && k < 2000);
        if (k >= 2000) miscompares++;
    endtask
    task automatic fw(input logic [23:0] a, input logic [15:0] d);
        axw(REG_ADDR, {8'h00, a}, rs);
        axw(REG_DATA, {16'h0000, d}, rs);
        poll(REG_STAT, 32'h0000_0100, 32'h0000_0000);
    endtask
    // Array words: address steps from the buffer start, pad after ten words
    always @(posedge aclk) begin
        if (a_we === 1'b1) begin
            chk({8'h00, a_addr}, {8'h00, WA + nwe[23:0]});
            chk({16'h0000, a_data}, nwe < 10 ? 32'h0000_A000 + nwe : 32'h0000_FFFF);
            nwe = nwe + 1;
        end
    end
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    initial begin
        #(25 * 60000);
        miscompares++;
        results();
    end
    initial begin
        {aresetn, lockout, locked, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) axw(rows[i].a, rows[i].d, rs);
            else axr(rows[i].a, rd, rs);
            chk({30'h0, rs}, {30'h0, rows[i].r});
            if (!rows[i].wr) chk(rd, rows[i].d);
        end
        fw(WA, CMD_SETUP);
        fw(WA, 16'h00FF);
        axr(REG_STAT, rd, rs);
        chk(rd, 32'h0000_0080);
        for (int e = 0; e < 3; e++) begin
            locked <= (e == 0);
            lockout <= (e == 1);
            fw(WA, CMD_SETUP);
            fw(WA, CMD_CONFIRM);
            poll(REG_STAT, 32'h0000_0081, e < 2 ? 32'h0000_0080 : 32'h0000_0000);
            if (e == 2) fw(WA + 24'h00_0005, 16'h1234);
            poll(REG_STAT, 32'h0000_0080, 32'h0000_0080);
            chk(rd, e == 0 ? 32'h0000_0092 : e == 1 ? 32'h0000_0098 : 32'h0000_0090);
            fw(WA, CMD_CLR_STATUS);
        end
        fw(WA, CMD_SETUP);
        fw(WA, CMD_CONFIRM);
        poll(REG_STAT, 32'h0000_0081, 32'h0000_0000);
        axw(REG_CTRL, 32'h0000_0009, rs);
        for (int i = 0; i < 10; i++) begin
            axw(REG_DATA, 32'h0000_A000 + i, rs);
            poll(REG_STAT, 32'h0000_0100, 32'h0000_0000);
        end
        axw(REG_CTRL, 32'h0000_000B, rs);
        for (n = 0; nwe < 512 && n < 5000; n++) @(posedge aclk);
        poll(REG_STAT, 32'h0000_0001, 32'h0000_0000);
        chk(nwe, 512);
        chk(rd, 32'h0000_0000);
        axw(REG_CTRL, 32'h0000_0008, rs);
        fw(WA, 16'h1111);
        fw(WA, 16'h2222);
        fw(24'h05_0000, PAD_WORD);
        poll(REG_STAT, 32'h0000_0080, 32'h0000_0080);
        chk(rd, 32'h0000_0080);
        chk(nwe, 512);
        results();
    end
endmodule // tb_top
`default_nettype wire

// [hdl/bfps_device.sv]
// Flash-side factory buffer program sequencer with its 512-word buffer.
// Assumes host writes arrive on aclk; supply lockout is an async pin.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Start only on setup then confirm, same block
// - Phases run setup, program/verify, then exit
// - Buffer load count fixed at 512 words
// - Array address advances to next buffer boundary
// - Array address wraps inside the target block
// - Setup check clears ready, flags lock/supply errors
// - Reads return status; status command becomes data
// - Busy flag set until buffer reached array
// - Words fill buffer from zero; program when full
// - Host pads short buffers with all-ones words
// - Out-of-block write mid fill discards buffer
// - Host aligns first word address to buffer
// - Misaligned start aborts with program fail
// - Host holds first word address constant
// - Writes ignored while array programming runs
// - All-ones write to other block enters exit
// - Factory programming rejects suspend, one block
// - Suspend halts at safe point, sets ready/suspended
// - Only reads and resume while suspended
// - Resume restarts, clears ready and suspended
// - Suspended: chip-select off gives standby; reset resets
// - Supply lockout halts programming, sets supply error
module bfps_device #(
    parameter bit ALLOW_SUSPEND = 1'b0
) (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    bfps_link_if.dev                         link,
    input  wire logic                        supply_lockout_level,
    input  wire logic                        block_locked,
    output logic                             array_we,
    output logic [bfps_pkg::ADDR_W-1:0]      array_addr,
    output logic [bfps_pkg::DATA_W-1:0]      array_data,
    output logic                             standby
);
    import bfps_pkg::*;

    bfps_dstate_t                state;
    logic [1:0]                  supply_sync;
    logic                        supply_low;
    logic [7:0]                  status;
    logic [ADDR_W-1:BLK_W]       block_base;
    logic [BLK_W-1:0]            prog_off;
    logic [BUF_W-1:0]            fill_cnt;
    logic [BUF_W-1:0]            prog_cnt;
    logic                        first_word;
    logic [TMR_W-1:0]            timer;
    logic [DATA_W-1:0]           buffer [BUF_WORDS];
    logic                        wr;
    logic                        in_blk;
    logic                        misaligned;
    logic                        susp_req;
    logic                        prog_step;
    logic                        dev_rst;

    assign wr         = link.wr_en && link.chip_en;
    assign in_blk     = link.wr_addr[ADDR_W-1:BLK_W] == block_base;
    assign misaligned = link.wr_addr[BUF_W-1:0] != BUF_ZERO;
    assign susp_req   = ALLOW_SUSPEND && wr && link.wr_data == CMD_SUSPEND;
    assign prog_step  = state == DS_PROG && !supply_low && !susp_req;
    assign dev_rst    = !aresetn || !link.reset_n;

    // Supply lockout synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            supply_sync <= 2'b00;
        end else begin
            supply_sync <= {supply_sync[0], supply_lockout_level};
        end
    end
    assign supply_low = supply_sync[1];

    // Sequencer and status
    always_ff @(posedge aclk) begin
        if (dev_rst) begin
            state      <= DS_IDLE;
            status     <= ST_IDLE_VAL;
            block_base <= '0;
            prog_off   <= '0;
            fill_cnt   <= '0;
            prog_cnt   <= '0;
            first_word <= 1'b0;
            timer      <= '0;
        end else begin
            unique case (state)
                DS_IDLE: begin
                    if (wr && link.wr_data == CMD_SETUP) begin
                        state      <= DS_SETUP;
                        block_base <= link.wr_addr[ADDR_W-1:BLK_W];
                    end else if (wr && link.wr_data == CMD_CLR_STATUS) begin
                        status <= ST_IDLE_VAL;
                    end
                end
                DS_SETUP: begin
                    if (wr) begin
                        if (link.wr_data == CMD_CONFIRM && in_blk) begin
                            state            <= DS_CHECK;
                            status[ST_READY] <= 1'b0;
                            status[ST_BUSY]  <= 1'b1;
                            timer            <= '0;
                        end else begin
                            state <= DS_IDLE;
                        end
                    end
                end
                DS_CHECK: begin
                    if (timer == TMR_W'(SETUP_CYCLES - 1)) begin
                        if (block_locked || supply_low) begin
                            // Lock status is read whatever the supply level
                            status[ST_FAIL]   <= 1'b1;
                            status[ST_LOCK]   <= block_locked;
                            status[ST_SUPPLY] <= supply_low;
                            status[ST_BUSY]   <= 1'b0;
                            status[ST_READY]  <= 1'b1;
                            state             <= DS_IDLE;
                        end else begin
                            state           <= DS_FILL;
                            status[ST_BUSY] <= 1'b0;
                            fill_cnt        <= '0;
                            first_word      <= 1'b1;
                        end
                    end else begin
                        timer <= timer + 1'b1;
                    end
                end
                DS_FILL: begin
                    if (wr) begin
                        if (!in_blk) begin
                            // Partial fill is dropped; exit ends here
                            state            <= DS_IDLE;
                            status[ST_READY] <= 1'b1;
                        end else if (first_word && misaligned) begin
                            status[ST_FAIL]  <= 1'b1;
                            status[ST_READY] <= 1'b1;
                            state            <= DS_IDLE;
                        end else begin
                            first_word <= 1'b0;
                            if (first_word) begin
                                prog_off <= link.wr_addr[BLK_W-1:0];
                            end
                            fill_cnt <= fill_cnt + 1'b1;
                            if (fill_cnt == BUF_LAST) begin
                                state           <= DS_PROG;
                                status[ST_BUSY] <= 1'b1;
                                prog_cnt        <= '0;
                            end
                        end
                    end
                end
                DS_PROG: begin
                    // Other writes are dropped here
                    if (supply_low) begin
                        status[ST_FAIL]   <= 1'b1;
                        status[ST_SUPPLY] <= 1'b1;
                        status[ST_BUSY]   <= 1'b0;
                        status[ST_READY]  <= 1'b1;
                        state             <= DS_IDLE;
                    end else if (susp_req) begin
                        status[ST_READY] <= 1'b1;
                        status[ST_SUSP]  <= 1'b1;
                        state            <= DS_SUSP;
                    end else begin
                        prog_cnt <= prog_cnt + 1'b1;
                        prog_off <= prog_off + 1'b1;
                        if (prog_cnt == BUF_LAST) begin
                            status[ST_BUSY] <= 1'b0;
                            fill_cnt        <= '0;
                            state           <= DS_FILL;
                        end
                    end
                end
                DS_SUSP: begin
                    // Read commands need no action; only resume leaves
                    if (wr && link.wr_data == CMD_RESUME) begin
                        status[ST_READY] <= 1'b0;
                        status[ST_SUSP]  <= 1'b0;
                        state            <= DS_PROG;
                    end
                end
            endcase
        end
    end

    // Buffer fill, data stored even if it looks like a command
    always_ff @(posedge aclk) begin
        if (state == DS_FILL && wr && in_blk) begin
            buffer[fill_cnt] <= link.wr_data;
        end
    end

    // Array write port
    always_ff @(posedge aclk) begin
        if (dev_rst) begin
            array_we   <= 1'b0;
            array_addr <= '0;
            array_data <= '0;
        end else begin
            array_we   <= prog_step;
            array_addr <= {block_base, prog_off};
            array_data <= buffer[prog_cnt];
        end
    end

    // Standby while suspended
    always_ff @(posedge aclk) begin
        if (dev_rst) begin
            standby <= 1'b0;
        end else begin
            standby <= state == DS_SUSP && !link.chip_en;
        end
    end

    assign link.rd_data = {ST_HIGH_PAD, status};
endmodule // bfps_device
`default_nettype wire

// [hdl/bfps_host.sv]
// Host controller: AXI4-Lite registers drive writes onto the flash bus.
// Assumes the sequencer shares aclk; status is sampled every cycle.
`timescale 1ns/1ps
`default_nettype none
module bfps_host (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    bfps_link_if.host                    link,
    input  wire logic [3:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [3:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready
);
    import bfps_pkg::*;

    bfps_hstate_t              state;
    logic                      aw_hold;
    logic                      w_hold;
    logic [3:0]                aw_q;
    logic [31:0]               w_q;
    logic [3:0]                strb_q;
    logic [3:0]                ctrl;
    logic [31:0]               addr_reg;
    logic [31:0]               data_reg;
    logic [7:0]                last_status;
    logic                      pend;
    logic                      align_err;
    logic [BUF_W-1:0]          fill_words;
    logic                      first_word;
    logic                      do_wr;
    logic                      pad_on;
    logic                      can_send;
    logic                      bad_start;
    logic [31:0]               wmask;

    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_wr  = aw_hold && w_hold && !s_axi_bvalid;
    assign wmask  = {{8{strb_q[3]}}, {8{strb_q[2]}}, {8{strb_q[1]}}, {8{strb_q[0]}}};
    assign pad_on = ctrl[CTRL_STREAM] && ctrl[CTRL_PAD] && !pend;
    // New buffer only once the previous one reached the array
    assign can_send  = !ctrl[CTRL_STREAM] || fill_words != BUF_ZERO
                       || !link.rd_data[ST_BUSY];
    assign bad_start = ctrl[CTRL_STREAM] && first_word && pend
                       && addr_reg[BUF_W-1:0] != BUF_ZERO;

    // Write address and data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold      <= 1'b0;
            w_hold       <= 1'b0;
            aw_q         <= '0;
            w_q          <= '0;
            strb_q       <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_q    <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_q    <= s_axi_wdata;
                strb_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_hold      <= 1'b0;
                w_hold       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_q == REG_CTRL || aw_q == REG_ADDR
                                 || aw_q == REG_DATA) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            unique case (s_axi_araddr)
                REG_CTRL: s_axi_rdata <= {28'h000_0000, ctrl};
                REG_ADDR: s_axi_rdata <= addr_reg;
                REG_DATA: s_axi_rdata <= data_reg;
                REG_STAT: s_axi_rdata <= {22'h00_0000, align_err, pend, last_status};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl     <= CTRL_RST_VAL;
            addr_reg <= '0;
            data_reg <= '0;
        end else begin
            if (do_wr && aw_q == REG_CTRL) begin
                ctrl <= (ctrl & ~wmask[3:0]) | (w_q[3:0] & wmask[3:0]);
            end else if (state == HS_SEND && !pend && fill_words == BUF_ZERO) begin
                ctrl[CTRL_PAD] <= 1'b0;
            end
            if (do_wr && aw_q == REG_ADDR) begin
                addr_reg <= (addr_reg & ~wmask) | (w_q & wmask);
            end
            if (do_wr && aw_q == REG_DATA) begin
                data_reg <= (data_reg & ~wmask) | (w_q & wmask);
            end
        end
    end

    // Flash bus writer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state        <= HS_IDLE;
            pend         <= 1'b0;
            align_err    <= 1'b0;
            fill_words   <= '0;
            first_word   <= 1'b0;
            last_status  <= ST_IDLE_VAL;
            link.wr_en   <= 1'b0;
            link.wr_addr <= '0;
            link.wr_data <= '0;
        end else begin
            last_status <= link.rd_data[7:0];
            if (do_wr && aw_q == REG_CTRL && w_q[CTRL_STREAM] && strb_q[0]
                && !ctrl[CTRL_STREAM]) begin
                first_word <= 1'b1;
                fill_words <= '0;
                align_err  <= 1'b0;
            end
            if (do_wr && aw_q == REG_DATA) begin
                pend <= 1'b1;
            end
            unique case (state)
                HS_IDLE: begin
                    if (bad_start) begin
                        pend      <= 1'b0;
                        align_err <= 1'b1;
                    end else if ((pend || pad_on) && can_send) begin
                        state        <= HS_SEND;
                        link.wr_en   <= 1'b1;
                        link.wr_addr <= addr_reg[ADDR_W-1:0];
                        link.wr_data <= pend ? data_reg[DATA_W-1:0] : PAD_WORD;
                        pend         <= 1'b0;
                        if (ctrl[CTRL_STREAM]) begin
                            fill_words <= fill_words + 1'b1;
                            first_word <= 1'b0;
                        end
                    end
                end
                HS_SEND: begin
                    link.wr_en <= 1'b0;
                    state      <= HS_IDLE;
                end
            endcase
        end
    end

    assign link.reset_n = !ctrl[CTRL_RESET];
    assign link.chip_en = ctrl[CTRL_CE];
endmodule // bfps_host
`default_nettype wire

// [include/bfps_link_if.sv]
// Flash bus between the host controller and the sequencer.
// Assumes both ends run on aclk; the bench joins the modports.
`timescale 1ns/1ps
`default_nettype none
interface bfps_link_if (input wire logic aclk);
    logic                            reset_n;
    logic                            chip_en;
    logic                            wr_en;
    logic [bfps_pkg::ADDR_W-1:0]     wr_addr;
    logic [bfps_pkg::DATA_W-1:0]     wr_data;
    logic [bfps_pkg::DATA_W-1:0]     rd_data;
    modport dev  (input aclk, reset_n, chip_en, wr_en, wr_addr, wr_data, output rd_data);
    modport host (input aclk, rd_data, output reset_n, chip_en, wr_en, wr_addr, wr_data);
endinterface
`default_nettype wire

// [include/bfps_pkg.sv]
// Shared constants for the factory buffer program sequencer and its host.
// Assumes one 40 MHz clock shared by both ends of the flash bus.
`default_nettype none
package bfps_pkg;
    localparam int DATA_W    = 16;
    localparam int ADDR_W    = 24;
    localparam int BLK_W     = 16;
    localparam int BUF_W     = 9;
    localparam int BUF_WORDS = 512;
    localparam logic [BUF_W-1:0] BUF_LAST = 9'h1FF;
    localparam logic [BUF_W-1:0] BUF_ZERO = 9'h000;
    localparam logic [DATA_W-1:0] CMD_SETUP      = 16'h0080;
    localparam logic [DATA_W-1:0] CMD_CONFIRM    = 16'h00D0;
    localparam logic [DATA_W-1:0] CMD_SUSPEND    = 16'h00B0;
    localparam logic [DATA_W-1:0] CMD_RESUME     = 16'h00D0;
    localparam logic [DATA_W-1:0] CMD_CLR_STATUS = 16'h0050;
    localparam logic [DATA_W-1:0] PAD_WORD       = 16'hFFFF;
    // Status bit positions
    localparam int ST_READY = 7;
    localparam int ST_FAIL  = 4;
    localparam int ST_SUPPLY = 3;
    localparam int ST_SUSP  = 2;
    localparam int ST_LOCK  = 1;
    localparam int ST_BUSY  = 0;
    localparam logic [7:0] ST_IDLE_VAL = 8'h80;
    localparam logic [7:0] ST_HIGH_PAD = 8'h00;
    // Setup check time
    localparam int CLK_PERIOD_PS = 25000;
    localparam int T_SETUP_NS    = 500;
    localparam int SETUP_CYCLES  = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TMR_W         = 6;
    // Host registers
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h4;
    localparam logic [3:0] REG_DATA = 4'h8;
    localparam logic [3:0] REG_STAT = 4'hC;
    localparam int CTRL_STREAM = 0;
    localparam int CTRL_PAD    = 1;
    localparam int CTRL_RESET  = 2;
    localparam int CTRL_CE     = 3;
    localparam logic [3:0] CTRL_RST_VAL = 4'h8;
    localparam int STAT_PEND   = 8;
    localparam int STAT_ALIGN  = 9;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [5:0] {
        DS_IDLE  = 6'b00_0001,
        DS_SETUP = 6'b00_0010,
        DS_CHECK = 6'b00_0100,
        DS_FILL  = 6'b00_1000,
        DS_PROG  = 6'b01_0000,
        DS_SUSP  = 6'b10_0000
    } bfps_dstate_t;
    typedef enum logic [1:0] {
        HS_IDLE = 2'b01,
        HS_SEND = 2'b10
    } bfps_hstate_t;
endpackage
`default_nettype wire
